// file: rtl/apm_pkg.sv
// Package for the converter power-mode control block.
// Assumes a single 100 MHz system clock standing in for the sample clock.
package apm_pkg;

  localparam int APM_DATA_W = 14;
  localparam int APM_CLK_MHZ = 100;
  // Recovery after nap, in sample-clock cycles
  localparam int APM_NAP_RECOVERY_CYC = 100;
  // Recovery after sleep, in milliseconds
  localparam int APM_SLEEP_RECOVERY_MS = 2;
  localparam int APM_SLEEP_RECOVERY_CYC = APM_SLEEP_RECOVERY_MS * 1000 * 1000 / 10;
  localparam int APM_CNT_W = 24;

  typedef enum {
    APM_NORMAL,
    APM_SLEEP,
    APM_NAP
  } apm_mode_t;

  // Sample word with its overrange flag
  typedef struct packed {
    logic overrange_flag;
    logic [APM_DATA_W-1:0] data;
  } apm_sample_t;

endpackage

// file: rtl/apm_power_mode_control.sv
// Power-mode control of a pipelined converter: mode decode, output
// tri-state control and recovery masking of the conversion data.
// Assumes pins are synchronous to clk; the core sample arrives each cycle.
//
// Overview of operation
// [RULE_01] Power-down select low means normal conversion regardless of output enable.
// [RULE_02] Power-down high and enable_n high selects sleep; reference off.
// [RULE_03] After sleep, samples are invalid for milliseconds while reference settles.
// [RULE_04] Power-down high and enable_n low selects nap; reference stays on.
// [RULE_05] After nap, about 100 clock cycles pass before data is valid.
// [RULE_06] Sleep and nap put every digital output in high impedance.
// [RULE_07] Output enable_n high disables all data outputs including overrange flag.
// [RULE_08] Capture side counts recovery after release and discards samples meanwhile.
`timescale 1ns/1ps
module apm_power_mode_control
  import apm_pkg::*;
#(
  parameter int SLEEP_RECOVERY_CYC = APM_SLEEP_RECOVERY_CYC,
  parameter int NAP_RECOVERY_CYC = APM_NAP_RECOVERY_CYC
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_select,
  input wire logic output_enable_n,
  input wire apm_sample_t core_sample,
  output logic [APM_DATA_W:0] dout_o,
  output logic [APM_DATA_W:0] dout_oe_n,
  output logic reference_on,
  output logic converter_on,
  output logic data_valid
);

  ////////////////////////////////////////////////////////////////////////
  apm_mode_t mode_reg;
  apm_mode_t mode_next;
  logic [APM_CNT_W-1:0] recov_reg;
  logic [APM_DATA_W:0] dout_reg;
  logic [APM_DATA_W:0] oe_n_reg;
  logic ref_reg;
  logic conv_reg;
  logic valid_reg;

  always_comb
  begin
    mode_next = APM_NORMAL; // RULE_01
    if (power_down_select)
    begin
      if (output_enable_n)
        mode_next = APM_SLEEP; // RULE_02
      else
        mode_next = APM_NAP; // RULE_04
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode_reg <= APM_NORMAL;
    else
      mode_reg <= mode_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Recovery counter loads on leaving a low-power mode. The sleep settle
  // starts when sleep ends, even into nap, since the reference restarts cold.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      recov_reg <= '0;
    else
    begin
      case (mode_reg)
        APM_SLEEP:
        begin
          if (mode_next != APM_SLEEP)
            recov_reg <= APM_CNT_W'(SLEEP_RECOVERY_CYC); // RULE_03
          else
            recov_reg <= '0;
        end
        APM_NAP:
        begin
          // Keep the longer of a running sleep settle and the nap figure
          if (mode_next == APM_NORMAL && recov_reg <= APM_CNT_W'(NAP_RECOVERY_CYC))
            recov_reg <= APM_CNT_W'(NAP_RECOVERY_CYC); // RULE_05
          else if (recov_reg != '0)
            recov_reg <= recov_reg - 1'b1;
        end
        APM_NORMAL:
        begin
          if (recov_reg != '0)
            recov_reg <= recov_reg - 1'b1;
        end
        default: recov_reg <= '0;
      endcase
    end
  end

  // Valid only in normal mode with recovery done; helps the capture side
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      valid_reg <= 1'b0;
    else
      valid_reg <= (mode_reg == APM_NORMAL) && (mode_next == APM_NORMAL) &&
                   (recov_reg <= APM_CNT_W'(1)); // RULE_08
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ref_reg <= 1'b0;
      conv_reg <= 1'b0;
    end
    else
    begin
      ref_reg <= (mode_next != APM_SLEEP); // RULE_02
      conv_reg <= (mode_next == APM_NORMAL); // RULE_04
    end
  end

  // Output drivers; oe_n low means the pins are driven
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      oe_n_reg <= '1;
      dout_reg <= '0;
    end
    else
    begin
      oe_n_reg <= (mode_next != APM_NORMAL || output_enable_n) ? '1 : '0; // RULE_06 RULE_07
      dout_reg <= core_sample;
    end
  end

  assign dout_o = dout_reg;
  assign dout_oe_n = oe_n_reg;
  assign reference_on = ref_reg;
  assign converter_on = conv_reg;
  assign data_valid = valid_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checker helpers: cycles since the last sleep and nap cycle, counted
  // apart from recov_reg so the recovery checks do not restate it.
  // Reset leaves both saturated: nothing pending to recover from.
  logic [APM_CNT_W-1:0] chk_sleep_age_reg;
  logic [APM_CNT_W-1:0] chk_nap_age_reg;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      chk_sleep_age_reg <= '1;
    else if (mode_reg == APM_SLEEP)
      chk_sleep_age_reg <= '0;
    else if (chk_sleep_age_reg != '1)
      chk_sleep_age_reg <= chk_sleep_age_reg + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      chk_nap_age_reg <= '1;
    else if (mode_reg == APM_NAP)
      chk_nap_age_reg <= '0;
    else if (chk_nap_age_reg != '1)
      chk_nap_age_reg <= chk_nap_age_reg + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Nap exit with no sleep settle still running
  sequence s_nap_exit;
    mode_reg == APM_NAP ##1
      (mode_reg == APM_NORMAL && chk_sleep_age_reg >= APM_CNT_W'(SLEEP_RECOVERY_CYC));
  endsequence

  sequence s_sleep_exit;
    mode_reg == APM_SLEEP ##1 mode_reg != APM_SLEEP;
  endsequence

  a_mode_normal_sel: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !power_down_select |=> mode_reg == APM_NORMAL)
    else $error("normal mode not taken");
  a_sleep_ref_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    power_down_select && output_enable_n |=> !ref_reg && mode_reg == APM_SLEEP)
    else $error("sleep does not drop reference");
  a_sleep_exit_mask: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    $fell(mode_reg == APM_SLEEP) |-> !valid_reg ##1 !valid_reg)
    else $error("data valid too soon after sleep");
  a_nap_ref_on: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
    power_down_select && !output_enable_n |=> ref_reg && !conv_reg)
    else $error("nap power state wrong");
  a_nap_exit_wait: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    s_nap_exit ##1 (mode_reg == APM_NORMAL)[*8] |-> !valid_reg)
    else $error("data valid too soon after nap");
  a_nap_exit_done: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    s_nap_exit |-> ##[1:102] (valid_reg || mode_reg != APM_NORMAL))
    else $error("nap recovery overran");
  a_lowpwr_hiz: assert property (@(posedge clk) disable iff (sys_rst) // RULE_06
    power_down_select |=> oe_n_reg == '1)
    else $error("outputs driven in low power");
  a_oe_disable: assert property (@(posedge clk) disable iff (sys_rst) // RULE_07
    output_enable_n |=> oe_n_reg[APM_DATA_W] && oe_n_reg == '1)
    else $error("outputs driven while disabled");
  a_valid_normal: assert property (@(posedge clk) disable iff (sys_rst) // RULE_08
    valid_reg |-> $past(mode_reg) == APM_NORMAL)
    else $error("valid outside normal mode");
  a_normal_drive: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !power_down_select && !output_enable_n |=> oe_n_reg == '0)
    else $error("outputs not driven in normal mode");
  a_normal_power: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !power_down_select |=> conv_reg && ref_reg)
    else $error("converter not powered in normal mode");
  a_data_pass: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
    !power_down_select |=> dout_reg == $past(core_sample))
    else $error("sample not passed to outputs");
  a_sleep_conv_off: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
    power_down_select && output_enable_n |=> !conv_reg)
    else $error("converter powered in sleep");
  a_sleep_exit_load: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    s_sleep_exit |-> recov_reg == APM_CNT_W'(SLEEP_RECOVERY_CYC))
    else $error("sleep settle not started");
  a_sleep_settle_age: assert property (@(posedge clk) disable iff (sys_rst) // RULE_03
    valid_reg |-> chk_sleep_age_reg >= APM_CNT_W'(SLEEP_RECOVERY_CYC))
    else $error("valid before sleep settle elapsed");
  a_nap_settle_age: assert property (@(posedge clk) disable iff (sys_rst) // RULE_05
    valid_reg |-> chk_nap_age_reg >= APM_CNT_W'(NAP_RECOVERY_CYC))
    else $error("valid before nap recovery elapsed");
  a_reset_quiet: assert property (@(posedge clk) // RULE_06
    sys_rst |=> oe_n_reg == '1 && !valid_reg && !ref_reg && !conv_reg)
    else $error("outputs not quiet after reset");

endmodule // apm_power_mode_control

// file: testbench/apm_capture_model.sv
// Capture-side model: marks samples valid only after recovery.
// Assumes pins it samples are synchronous to clk.
`timescale 1ns/1ps
module apm_capture_model
#(
  parameter int NAP_CYC = 100,
  parameter int SLEEP_CYC = 20
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_select,
  input wire logic output_enable_n,
  output logic capture_valid
);
  int wait_reg;
  // Reload while held down, so the count runs from release; a sleep
  // settle keeps running through a following nap
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wait_reg <= 0;
    else if (power_down_select && output_enable_n)
      wait_reg <= SLEEP_CYC;
    else if (power_down_select)
      wait_reg <= (wait_reg > NAP_CYC) ? wait_reg - 1 : NAP_CYC;
    else if (wait_reg > 0)
      wait_reg <= wait_reg - 1;
  end
  assign capture_valid = (wait_reg == 0);
endmodule // apm_capture_model

// file: testbench/apm_power_mode_control_tb.sv
// Random pin traffic plus nap and sleep recovery cases.
// Assumes the design and capture model above.
`timescale 1ns/1ps
module apm_power_mode_control_tb;
  import apm_pkg::*;
  localparam int NAP = 100;
  localparam int SLP = 20;
  logic clk, sys_rst, pd, oen, reference_on, converter_on, data_valid, cap_valid;
  apm_sample_t core_sample;
  logic [APM_DATA_W:0] dout_o, dout_oe_n;
  int failures, samples_checked, seed, n;
  apm_power_mode_control #(.SLEEP_RECOVERY_CYC(SLP), .NAP_RECOVERY_CYC(NAP)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .power_down_select(pd), .output_enable_n(oen),
    .core_sample(core_sample), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
    .reference_on(reference_on), .converter_on(converter_on), .data_valid(data_valid));
  apm_capture_model #(.NAP_CYC(NAP), .SLEEP_CYC(SLP)) i_cap (.clk(clk), .sys_rst(sys_rst),
    .power_down_select(pd), .output_enable_n(oen), .capture_valid(cap_valid));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [APM_DATA_W:0] seen, input logic [APM_DATA_W:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  function automatic logic [APM_DATA_W:0] exp_oe_n(input logic p, input logic o);
    return (p | o) ? '1 : '0;
  endfunction
  // Early check leaves slack for the typical, not exact, figure
  task automatic recover(input logic o, input int rec);
    pd = 1;
    oen = o;
    repeat (3) @(negedge clk);
    pd = 0;
    oen = 0;
    repeat (rec - 4) @(negedge clk);
    check(15'(data_valid), 15'h0000);
    check(15'(cap_valid), 15'h0000);
    n = 0;
    while (data_valid !== 1'b1 && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    check(15'(data_valid), 15'h0001);
    check(15'(cap_valid), 15'h0001);
    if (data_valid !== 1'b1)
      end_sim;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hB000;
    failures = 0;
    samples_checked = 0;
    {sys_rst, pd, oen, core_sample} = {3'h4, 15'h0000};
    repeat (8) @(negedge clk);
    sys_rst = 0;
    recover(1'b0, NAP);
    recover(1'b1, SLP);
    @(negedge clk);
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk);
      check(dout_oe_n, exp_oe_n(pd, oen));
      check(15'(converter_on), 15'(!pd));
      check(15'(reference_on), 15'(!(pd & oen)));
      check(dout_o, core_sample);
      if (pd === 1'b1)
      begin
        check(15'(data_valid), 15'h0000);
        check(15'(cap_valid), 15'h0000);
      end
      {pd, oen, core_sample} = 17'($random(seed));
    end
    end_sim;
  end
endmodule // apm_power_mode_control_tb
